// ### verilog/cbpwd_defines.svh
// Offsets, field positions, erased values and decode constants of the config decoder
`ifndef CBPWD_DEFINES_SVH
`define CBPWD_DEFINES_SVH

// ==========================================================================
// Byte addresses in configuration space
`define CBPWD_ADDR_WDT_CFG 22'h300005
`define CBPWD_ADDR_DBG_CFG 22'h300006
`define CBPWD_ADDR_WP_CFG 22'h300007
`define CBPWD_ADDR_CODE_CFG 22'h300008

// ==========================================================================
// Field positions
`define CBPWD_WDT_CCS_HI 5
`define CBPWD_WDT_CCS_LO 3
`define CBPWD_WDT_CWS_HI 2
`define CBPWD_WDT_CWS_LO 0
`define CBPWD_DEBUG_BIT 5
`define CBPWD_STORE_EN_BIT 4
`define CBPWD_BOOT_EN_BIT 3
`define CBPWD_BOOT_SIZE_HI 2
`define CBPWD_BOOT_SIZE_LO 0
`define CBPWD_APP_WP_BIT 7
`define CBPWD_STORE_WP_BIT 3
`define CBPWD_EE_WP_BIT 2
`define CBPWD_CFG_WP_BIT 1
`define CBPWD_BOOT_WP_BIT 0
`define CBPWD_CODE_PROT_BIT 0

// ==========================================================================
// Implemented bits (erased value is one on each of them)
`define CBPWD_IMPL_WDT_CFG 8'h3f
`define CBPWD_IMPL_DBG_CFG 8'h3f
`define CBPWD_IMPL_WP_CFG 8'h8f
`define CBPWD_IMPL_CODE_CFG 8'h01
// Bits that, once armed to zero, only a bulk erase returns to one
`define CBPWD_STICKY_WDT_CFG 8'h00
`define CBPWD_STICKY_DBG_CFG 8'h18
`define CBPWD_STICKY_WP_CFG 8'h8f
`define CBPWD_STICKY_CODE_CFG 8'h01
`define CBPWD_BOOT_SIZE_MASK 8'h07

// ==========================================================================
// Boot block end addresses
`define CBPWD_BOOT_END_111 22'h0003ff
`define CBPWD_BOOT_END_110 22'h0007ff
`define CBPWD_BOOT_END_101 22'h000fff
`define CBPWD_BOOT_END_100 22'h001fff
`define CBPWD_BOOT_END_011 22'h003fff
`define CBPWD_BOOT_END_010 22'h007fff
`define CBPWD_BOOT_END_00X 22'h00ffff

// Window delay in eighths of the period for code 000
`define CBPWD_WIN_DELAY_MAX 4'h7

`endif

// ### verilog/cbpwd_pkg.sv
// Types shared by the configuration byte decoder
package cbpwd_pkg;
  // Watchdog reference clock choice after decode
  typedef enum logic [2:0] {
    CBPWD_CLK_NONE = 3'b000,
    CBPWD_CLK_LFINT = 3'b001,
    CBPWD_CLK_MFINT = 3'b010,
    CBPWD_CLK_SECOSC = 3'b011,
    CBPWD_CLK_SOFT = 3'b100,
    CBPWD_CLK_RSVD = 3'b101
  } cbpwd_clk_src_e;
  typedef logic [21:0] cbpwd_addr_t;
endpackage

// ### verilog/cbpwd_cfg_byte.sv
// One configuration byte with sticky protection bits and bulk erase
module cbpwd_cfg_byte #(
  parameter logic [7:0] IMPL = 8'hff,
  parameter logic [7:0] STICKY = 8'h00
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] image,
  input wire logic erase,
  input wire logic wr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] lock_mask,
  output logic [7:0] q
);
  logic [7:0] free;
  logic [7:0] next_q;

  // Free bits follow data, sticky bits may only fall, locked bits hold
  always_comb begin
    free = IMPL & ~STICKY & ~lock_mask;
    next_q = (wr_data & free) | (q & lock_mask & IMPL)
      | (q & wr_data & STICKY & ~lock_mask);
  end

  // Reset reloads the nonvolatile image; erase beats a write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= image & IMPL;
    end else if (erase) begin
      q <= IMPL;
    end else if (wr) begin
      q <= next_q;
    end
  end
endmodule

// ### verilog/cbpwd_wdt_decode.sv
// Watchdog clock source and power-on window decode
`include "cbpwd_defines.svh"
module cbpwd_wdt_decode (
  input wire logic [1:0] mode,
  input wire logic [2:0] ccs,
  input wire logic [2:0] cws,
  input wire logic sleep,
  input wire logic sw_enable,
  output logic active,
  output cbpwd_pkg::cbpwd_clk_src_e clk_src,
  output logic [3:0] delay_eighths,
  output logic full_open
);
  // Mode 00 disables and ignores software enable and clock selector
  always_comb begin
    case (mode)
      2'h3: active = 1'b1;
      2'h2: active = ~sleep;
      2'h1: active = sw_enable;
      default: active = 1'b0;
    endcase
    if (mode == 2'h0) begin
      clk_src = cbpwd_pkg::CBPWD_CLK_NONE;
    end else if (ccs == 3'h7) begin
      clk_src = cbpwd_pkg::CBPWD_CLK_SOFT;
    end else if (ccs == 3'h2) begin
      clk_src = cbpwd_pkg::CBPWD_CLK_SECOSC;
    end else if (ccs == 3'h1) begin
      clk_src = cbpwd_pkg::CBPWD_CLK_MFINT;
    end else if (ccs == 3'h0) begin
      clk_src = cbpwd_pkg::CBPWD_CLK_LFINT;
    end else begin
      clk_src = cbpwd_pkg::CBPWD_CLK_RSVD;
    end
  end

  // Each code step up to 101 moves one eighth from delay to opening; codes 11x open fully with no delay
  always_comb begin
    full_open = cws[2] & cws[1];
    delay_eighths = full_open ? 4'h0 : `CBPWD_WIN_DELAY_MAX - {1'b0, cws};
  end
endmodule

// ### verilog/cbpwd_top.sv
// Configuration byte store and protection / watchdog decode
`include "cbpwd_defines.svh"
module cbpwd_top #(
  parameter int ADDR_W = 22
) (
  REF_CLK,
  NRST,
  NV_WDT_CFG,
  NV_DBG_CFG,
  NV_WP_CFG,
  NV_CP_CFG,
  WR_EN,
  WR_ADDR,
  WR_DATA,
  BULK_ERASE,
  RD_ADDR,
  RD_DATA,
  WR_REFUSED,
  WDT_OPERATING_MODE,
  WDT_SW_ENABLE,
  SLEEP,
  WDT_ACTIVE,
  WDT_CLK_SRC,
  WDT_WINDOW_DELAY,
  WDT_WINDOW_FULL_OPEN,
  DEBUG_ENABLE,
  STORAGE_REGION_ENABLE,
  BOOT_REGION_ENABLE,
  BOOT_REGION_END,
  APP_WRITE_BLOCK,
  STORAGE_WRITE_BLOCK,
  EEPROM_WRITE_BLOCK,
  CONFIG_WRITE_BLOCK,
  BOOT_WRITE_BLOCK,
  CODE_PROTECT
);
  input wire logic REF_CLK;
  input wire logic NRST;
  input wire logic [7:0] NV_WDT_CFG;
  input wire logic [7:0] NV_DBG_CFG;
  input wire logic [7:0] NV_WP_CFG;
  input wire logic [7:0] NV_CP_CFG;
  input wire logic WR_EN;
  input wire logic [ADDR_W-1:0] WR_ADDR;
  input wire logic [7:0] WR_DATA;
  input wire logic BULK_ERASE;
  input wire logic [ADDR_W-1:0] RD_ADDR;
  output logic [7:0] RD_DATA;
  output logic WR_REFUSED;
  input wire logic [1:0] WDT_OPERATING_MODE;
  input wire logic WDT_SW_ENABLE;
  input wire logic SLEEP;
  output logic WDT_ACTIVE;
  output cbpwd_pkg::cbpwd_clk_src_e WDT_CLK_SRC;
  output logic [3:0] WDT_WINDOW_DELAY;
  output logic WDT_WINDOW_FULL_OPEN;
  output logic DEBUG_ENABLE;
  output logic STORAGE_REGION_ENABLE;
  output logic BOOT_REGION_ENABLE;
  output logic [21:0] BOOT_REGION_END;
  output logic APP_WRITE_BLOCK;
  output logic STORAGE_WRITE_BLOCK;
  output logic EEPROM_WRITE_BLOCK;
  output logic CONFIG_WRITE_BLOCK;
  output logic BOOT_WRITE_BLOCK;
  output logic CODE_PROTECT;

  // ==========================================================================
  // Parameter check
  // Offsets are fixed 22-bit compares, so no other width can be served
  if (ADDR_W != 22) begin : g_addr_w_chk
    $error("cbpwd_top: ADDR_W must be 22");
  end

  // ==========================================================================
  // Write decode
  logic [7:0] wdt_cfg;
  logic [7:0] dbg_cfg;
  logic [7:0] wp_cfg;
  logic [7:0] code_cfg;
  logic hit_wdt;
  logic hit_dbg;
  logic hit_wp;
  logic hit_code;
  logic cfg_locked;
  logic wr_ok;
  logic [7:0] dbg_lock;

  // A write-protected config space accepts nothing but a bulk erase
  always_comb begin
    cfg_locked = ~wp_cfg[`CBPWD_CFG_WP_BIT];
    wr_ok = WR_EN & ~cfg_locked & ~BULK_ERASE;
    hit_wdt = 1'b0;
    hit_dbg = 1'b0;
    hit_wp = 1'b0;
    hit_code = 1'b0;
    if (WR_ADDR == `CBPWD_ADDR_WDT_CFG) begin
      hit_wdt = 1'b1;
    end else if (WR_ADDR == `CBPWD_ADDR_DBG_CFG) begin
      hit_dbg = 1'b1;
    end else if (WR_ADDR == `CBPWD_ADDR_WP_CFG) begin
      hit_wp = 1'b1;
    end else if (WR_ADDR == `CBPWD_ADDR_CODE_CFG) begin
      hit_code = 1'b1;
    end
  end

  // Size field is frozen once the boot block is enabled
  assign dbg_lock = dbg_cfg[`CBPWD_BOOT_EN_BIT] ? 8'h00 : `CBPWD_BOOT_SIZE_MASK;

  // ==========================================================================
  // Byte store: sticky bits only fall, erase restores ones
  cbpwd_cfg_byte #(.IMPL(`CBPWD_IMPL_WDT_CFG), .STICKY(`CBPWD_STICKY_WDT_CFG)) u_wdt (
    .clk(REF_CLK), .nrst(NRST), .image(NV_WDT_CFG), .erase(BULK_ERASE),
    .wr(wr_ok & hit_wdt), .wr_data(WR_DATA), .lock_mask(8'h00), .q(wdt_cfg));
  cbpwd_cfg_byte #(.IMPL(`CBPWD_IMPL_DBG_CFG), .STICKY(`CBPWD_STICKY_DBG_CFG)) u_dbg (
    .clk(REF_CLK), .nrst(NRST), .image(NV_DBG_CFG), .erase(BULK_ERASE),
    .wr(wr_ok & hit_dbg), .wr_data(WR_DATA), .lock_mask(dbg_lock), .q(dbg_cfg));
  cbpwd_cfg_byte #(.IMPL(`CBPWD_IMPL_WP_CFG), .STICKY(`CBPWD_STICKY_WP_CFG)) u_wp (
    .clk(REF_CLK), .nrst(NRST), .image(NV_WP_CFG), .erase(BULK_ERASE),
    .wr(wr_ok & hit_wp), .wr_data(WR_DATA), .lock_mask(8'h00), .q(wp_cfg));
  cbpwd_cfg_byte #(.IMPL(`CBPWD_IMPL_CODE_CFG), .STICKY(`CBPWD_STICKY_CODE_CFG)) u_code (
    .clk(REF_CLK), .nrst(NRST), .image(NV_CP_CFG), .erase(BULK_ERASE),
    .wr(wr_ok & hit_code), .wr_data(WR_DATA), .lock_mask(8'h00), .q(code_cfg));

  // ==========================================================================
  // Read port and refusal flag
  // Refusal is a one-cycle pulse so a programmer can count rejected bytes
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      WR_REFUSED <= 1'b0;
    end else begin
      WR_REFUSED <= WR_EN & ~BULK_ERASE
        & (cfg_locked | ~(hit_wdt | hit_dbg | hit_wp | hit_code));
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      RD_DATA <= 8'h00;
    end else if (RD_ADDR == `CBPWD_ADDR_WDT_CFG) begin
      RD_DATA <= wdt_cfg;
    end else if (RD_ADDR == `CBPWD_ADDR_DBG_CFG) begin
      RD_DATA <= dbg_cfg;
    end else if (RD_ADDR == `CBPWD_ADDR_WP_CFG) begin
      RD_DATA <= wp_cfg;
    end else if (RD_ADDR == `CBPWD_ADDR_CODE_CFG) begin
      RD_DATA <= code_cfg;
    end else begin
      RD_DATA <= 8'h00;
    end
  end

  // ==========================================================================
  // Watchdog decode
  logic wdt_active;
  cbpwd_pkg::cbpwd_clk_src_e wdt_src;
  logic [3:0] win_delay;
  logic win_open;

  cbpwd_wdt_decode u_wdt_dec (
    .mode(WDT_OPERATING_MODE),
    .ccs(wdt_cfg[`CBPWD_WDT_CCS_HI:`CBPWD_WDT_CCS_LO]),
    .cws(wdt_cfg[`CBPWD_WDT_CWS_HI:`CBPWD_WDT_CWS_LO]),
    .sleep(SLEEP),
    .sw_enable(WDT_SW_ENABLE),
    .active(wdt_active),
    .clk_src(wdt_src),
    .delay_eighths(win_delay),
    .full_open(win_open)
  );

  // Registered so downstream sees glitch-free selects
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      WDT_ACTIVE <= 1'b0;
      WDT_CLK_SRC <= cbpwd_pkg::CBPWD_CLK_NONE;
      WDT_WINDOW_DELAY <= 4'h0;
      WDT_WINDOW_FULL_OPEN <= 1'b1;
    end else begin
      WDT_ACTIVE <= wdt_active;
      WDT_CLK_SRC <= wdt_src;
      WDT_WINDOW_DELAY <= win_delay;
      WDT_WINDOW_FULL_OPEN <= win_open;
    end
  end

  // ==========================================================================
  // Region and boot decode
  logic [21:0] boot_end;

  always_comb begin
    case (dbg_cfg[`CBPWD_BOOT_SIZE_HI:`CBPWD_BOOT_SIZE_LO])
      3'h7: boot_end = `CBPWD_BOOT_END_111;
      3'h6: boot_end = `CBPWD_BOOT_END_110;
      3'h5: boot_end = `CBPWD_BOOT_END_101;
      3'h4: boot_end = `CBPWD_BOOT_END_100;
      3'h3: boot_end = `CBPWD_BOOT_END_011;
      3'h2: boot_end = `CBPWD_BOOT_END_010;
      default: boot_end = `CBPWD_BOOT_END_00X;
    endcase
  end

  // Enables are active low in storage; outputs are active high
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      DEBUG_ENABLE <= 1'b0;
      STORAGE_REGION_ENABLE <= 1'b0;
      BOOT_REGION_ENABLE <= 1'b0;
      BOOT_REGION_END <= 22'h000000;
    end else begin
      DEBUG_ENABLE <= ~dbg_cfg[`CBPWD_DEBUG_BIT];
      STORAGE_REGION_ENABLE <= ~dbg_cfg[`CBPWD_STORE_EN_BIT];
      BOOT_REGION_ENABLE <= ~dbg_cfg[`CBPWD_BOOT_EN_BIT];
      // No boot block means the size field reads out as zero end
      BOOT_REGION_END <= dbg_cfg[`CBPWD_BOOT_EN_BIT] ? 22'h000000 : boot_end;
    end
  end

  // ==========================================================================
  // Write and code protection
  // Region protects gate on the region existing at all
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      APP_WRITE_BLOCK <= 1'b0;
      STORAGE_WRITE_BLOCK <= 1'b0;
      EEPROM_WRITE_BLOCK <= 1'b0;
      CONFIG_WRITE_BLOCK <= 1'b0;
      BOOT_WRITE_BLOCK <= 1'b0;
      CODE_PROTECT <= 1'b0;
    end else begin
      APP_WRITE_BLOCK <= ~wp_cfg[`CBPWD_APP_WP_BIT];
      STORAGE_WRITE_BLOCK <= ~wp_cfg[`CBPWD_STORE_WP_BIT]
        & ~dbg_cfg[`CBPWD_STORE_EN_BIT];
      EEPROM_WRITE_BLOCK <= ~wp_cfg[`CBPWD_EE_WP_BIT];
      CONFIG_WRITE_BLOCK <= ~wp_cfg[`CBPWD_CFG_WP_BIT];
      BOOT_WRITE_BLOCK <= ~wp_cfg[`CBPWD_BOOT_WP_BIT] & ~dbg_cfg[`CBPWD_BOOT_EN_BIT];
      CODE_PROTECT <= ~code_cfg[`CBPWD_CODE_PROT_BIT];
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  sequence erase_seq;
    BULK_ERASE;
  endsequence
  sequence all_ones_seq;
    wdt_cfg == `CBPWD_IMPL_WDT_CFG && dbg_cfg == `CBPWD_IMPL_DBG_CFG
      && wp_cfg == `CBPWD_IMPL_WP_CFG && code_cfg == `CBPWD_IMPL_CODE_CFG;
  endsequence
  sequence wdt_write_seq;
    wr_ok && hit_wdt;
  endsequence

  bulk_erase_ones_a: assert property (erase_seq |=> all_ones_seq)
    else $error("bulk erase left a config bit at zero");
  byte_six_store_a: assert property (wdt_write_seq |=> wdt_cfg == (8'h3f & $past(WR_DATA)))
    else $error("byte six did not store its fields");
  sticky_wp_a: assert property (!$past(BULK_ERASE) |-> (wp_cfg & ~$past(wp_cfg)) == 8'h00)
    else $error("write protect bit cleared without erase");
  sticky_code_a: assert property (!$past(BULK_ERASE) && !$past(code_cfg[0]) |-> !code_cfg[0])
    else $error("code protect cleared without erase");
  size_freeze_a: assert property (!dbg_cfg[3] && !BULK_ERASE |=> $stable(dbg_cfg[2:0]))
    else $error("boot size changed while boot enabled");
  cfg_lock_a: assert property (!wp_cfg[1] && WR_EN && !BULK_ERASE |=> WR_REFUSED
      && $stable(wdt_cfg) && $stable(dbg_cfg) && $stable(code_cfg))
    else $error("write accepted while config protected");
  wdt_off_a: assert property (WDT_OPERATING_MODE == 2'h0 |=> !WDT_ACTIVE
      && WDT_CLK_SRC == cbpwd_pkg::CBPWD_CLK_NONE)
    else $error("watchdog not off in mode zero");
  clk_soft_a: assert property (WDT_OPERATING_MODE != 2'h0 && wdt_cfg[5:3] == 3'h7
      |=> WDT_CLK_SRC == cbpwd_pkg::CBPWD_CLK_SOFT)
    else $error("selector 111 not software control");
  clk_osc_a: assert property (WDT_OPERATING_MODE != 2'h0 && wdt_cfg[5:3] == 3'h1
      |=> WDT_CLK_SRC == cbpwd_pkg::CBPWD_CLK_MFINT)
    else $error("selector 001 not medium oscillator");
  window_code_a: assert property (wdt_cfg[2:0] == 3'h0 |=> WDT_WINDOW_DELAY == 4'h7
      && !WDT_WINDOW_FULL_OPEN)
    else $error("window code 000 wrong delay");
  boot_end_a: assert property (!dbg_cfg[3] && dbg_cfg[2:0] == 3'h7
      |=> BOOT_REGION_END == 22'h0003ff && BOOT_REGION_ENABLE)
    else $error("boot end wrong for size 111");
  storage_wp_a: assert property (dbg_cfg[4] |=> !STORAGE_WRITE_BLOCK)
    else $error("storage protect active with region off");
  boot_wp_a: assert property (dbg_cfg[3] |=> !BOOT_WRITE_BLOCK && BOOT_REGION_END == 22'h0)
    else $error("boot protect active with no boot block");
  // The first edge after release still shows reset values, so skip it
  code_prot_a: assert property ($past(NRST) |-> CODE_PROTECT == !$past(code_cfg[0]))
    else $error("code protect output mismatch");
  debug_en_a: assert property ($past(NRST) |-> DEBUG_ENABLE == !$past(dbg_cfg[5]))
    else $error("debugger enable mismatch");
  app_wp_a: assert property ($past(NRST) |-> APP_WRITE_BLOCK == !$past(wp_cfg[7])
      && EEPROM_WRITE_BLOCK == !$past(wp_cfg[2]))
    else $error("application or eeprom block mismatch");
  storage_en_a: assert property ($past(NRST)
      |-> STORAGE_REGION_ENABLE == !$past(dbg_cfg[4]))
    else $error("storage region enable mismatch");
  boot_en_a: assert property ($past(NRST) |-> BOOT_REGION_ENABLE == !$past(dbg_cfg[3]))
    else $error("boot region enable mismatch");
  cfg_wb_a: assert property ($past(NRST) |-> CONFIG_WRITE_BLOCK == !$past(wp_cfg[1]))
    else $error("config write block mismatch");
  sticky_dbg_a: assert property (!$past(BULK_ERASE)
      |-> (dbg_cfg & ~$past(dbg_cfg) & `CBPWD_STICKY_DBG_CFG) == 8'h00)
    else $error("region enable cleared without erase");

  // Remaining selector codes and window corners
  clk_sec_a: assert property (WDT_OPERATING_MODE != 2'h0 && wdt_cfg[5:3] == 3'h2
      |=> WDT_CLK_SRC == cbpwd_pkg::CBPWD_CLK_SECOSC)
    else $error("selector 010 not secondary oscillator");
  clk_low_a: assert property (WDT_OPERATING_MODE != 2'h0 && wdt_cfg[5:3] == 3'h0
      |=> WDT_CLK_SRC == cbpwd_pkg::CBPWD_CLK_LFINT)
    else $error("selector 000 not low oscillator");
  clk_rsvd_a: assert property (WDT_OPERATING_MODE != 2'h0
      && wdt_cfg[5:3] > 3'h2 && wdt_cfg[5:3] != 3'h7
      |=> WDT_CLK_SRC == cbpwd_pkg::CBPWD_CLK_RSVD)
    else $error("reserved selector not flagged");
  window_open_a: assert property (wdt_cfg[2:1] == 2'h3 |=> WDT_WINDOW_FULL_OPEN
      && WDT_WINDOW_DELAY == 4'h0)
    else $error("window code 11x not fully open");
  window_step_a: assert property (wdt_cfg[2:0] == 3'h5 |=> WDT_WINDOW_DELAY == 4'h2
      && !WDT_WINDOW_FULL_OPEN)
    else $error("window code 101 wrong delay");

  // Region protection engages when its region is present and its protect bit is armed; boot end for size 00x
  boot_wp_on_a: assert property (!dbg_cfg[3] && !wp_cfg[0] |=> BOOT_WRITE_BLOCK)
    else $error("boot protect missing with boot block on");
  storage_wp_on_a: assert property (!dbg_cfg[4] && !wp_cfg[3] |=> STORAGE_WRITE_BLOCK)
    else $error("storage protect missing with region on");
  boot_size_max_a: assert property (!dbg_cfg[3] && dbg_cfg[2:1] == 2'h0
      |=> BOOT_REGION_END == 22'h00ffff)
    else $error("boot end wrong for size 00x");
endmodule

// ### tb/cbpwd_top_tb_top.sv
// Self-checking bench of the configuration byte store and decoder
module cbpwd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Stimulus, observed outputs and the reference byte image
  localparam logic [7:0] IMPL [4] = '{8'h3f, 8'h3f, 8'h8f, 8'h01};
  localparam logic [7:0] STICKY [4] = '{8'h00, 8'h18, 8'h8f, 8'h01};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] nv [4] = '{default: 8'hff};
  logic wr_en = 1'b0;
  logic [21:0] wr_addr = 22'h000000;
  logic [7:0] wr_data = 8'h00;
  logic bulk_erase = 1'b0;
  logic [21:0] rd_addr = 22'h000000;
  logic [1:0] wdt_mode = 2'h0;
  logic sw_en = 1'b0;
  logic sleep = 1'b0;
  logic [7:0] rd_data;
  logic wr_refused, wdt_active, full_open, dbg_en, store_en, boot_en;
  logic app_wb, store_wb, ee_wb, cfg_wb, boot_wb, cprot;
  cbpwd_pkg::cbpwd_clk_src_e clk_src;
  logic [3:0] win_delay;
  logic [21:0] boot_end;
  logic [7:0] b [4];
  logic [15:0] lfsr = 16'hf564;
  int err_count = 0;
  int n_compared = 0;

  // 10 MHz reference clock
  always #50 ref_clk = ~ref_clk;

  cbpwd_top #(.ADDR_W(22)) i_dut (
    .REF_CLK(ref_clk), .NRST(nrst), .NV_WDT_CFG(nv[0]), .NV_DBG_CFG(nv[1]),
    .NV_WP_CFG(nv[2]), .NV_CP_CFG(nv[3]), .WR_EN(wr_en), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .BULK_ERASE(bulk_erase), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
    .WR_REFUSED(wr_refused), .WDT_OPERATING_MODE(wdt_mode), .WDT_SW_ENABLE(sw_en),
    .SLEEP(sleep), .WDT_ACTIVE(wdt_active), .WDT_CLK_SRC(clk_src),
    .WDT_WINDOW_DELAY(win_delay), .WDT_WINDOW_FULL_OPEN(full_open),
    .DEBUG_ENABLE(dbg_en), .STORAGE_REGION_ENABLE(store_en), .BOOT_REGION_ENABLE(boot_en),
    .BOOT_REGION_END(boot_end), .APP_WRITE_BLOCK(app_wb), .STORAGE_WRITE_BLOCK(store_wb),
    .EEPROM_WRITE_BLOCK(ee_wb), .CONFIG_WRITE_BLOCK(cfg_wb), .BOOT_WRITE_BLOCK(boot_wb),
    .CODE_PROTECT(cprot)
  );

  // ==========================================================================
  // Expectation functions
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Sticky bits only fall by a write; a frozen size field keeps its old code
  function automatic logic [7:0] exp_store(input int i, input logic [7:0] old,
                                           input logic [7:0] d);
    logic [7:0] n;
    n = d & IMPL[i];
    n = (n & ~STICKY[i]) | (n & old & STICKY[i]);
    if (i == 1 && !old[3]) n[2:0] = old[2:0];
    return n;
  endfunction

  function automatic logic [2:0] exp_clk(input logic [1:0] m, input logic [2:0] s);
    if (m == 2'b00) return cbpwd_pkg::CBPWD_CLK_NONE;
    case (s)
      3'h7: return cbpwd_pkg::CBPWD_CLK_SOFT;
      3'h2: return cbpwd_pkg::CBPWD_CLK_SECOSC;
      3'h1: return cbpwd_pkg::CBPWD_CLK_MFINT;
      3'h0: return cbpwd_pkg::CBPWD_CLK_LFINT;
      default: return cbpwd_pkg::CBPWD_CLK_RSVD;
    endcase
  endfunction

  function automatic logic [21:0] exp_end(input logic [7:0] c);
    if (c[3]) return 22'h000000;
    case (c[2:0])
      3'h7: return 22'h0003ff;
      3'h6: return 22'h0007ff;
      3'h5: return 22'h000fff;
      3'h4: return 22'h001fff;
      3'h3: return 22'h003fff;
      3'h2: return 22'h007fff;
      default: return 22'h00ffff;
    endcase
  endfunction

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic roll(output logic [7:0] v);
    lfsr = lfsr_next(lfsr);
    v = lfsr[7:0];
  endtask

  // Strobes are left raised so back-to-back writes never toggle them in one step
  task automatic wr(input int i, input logic [7:0] d, input logic er);
    logic refuse;
    refuse = (i > 3) || !b[2][1];
    wr_en = 1'b1;
    wr_addr = 22'h300005 + 22'(i);
    wr_data = d;
    bulk_erase = er;
    @(posedge ref_clk);
    @(negedge ref_clk);
    if (er) begin
      chk("erase_refused", wr_refused, 1'b0);
      b = IMPL;
    end else begin
      chk("wr_refused", wr_refused, refuse);
      if (!refuse) b[i] = exp_store(i, b[i], d);
    end
  endtask

  // Reads every byte plus an unmapped one, then all decodes once settled
  task automatic check_all();
    logic act;
    wr_en = 1'b0;
    bulk_erase = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd_addr = 22'h300005 + 22'(i);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("rd_data", rd_data, (i < 4) ? b[i] : 8'h00);
    end
    act = (wdt_mode == 2'b11) || (wdt_mode == 2'b10 && !sleep) || (wdt_mode == 2'b01 && sw_en);
    chk("wdt_active", wdt_active, act);
    chk("clk_src", clk_src, exp_clk(wdt_mode, b[0][5:3]));
    chk("full_open", full_open, b[0][2:0] >= 3'h6);
    chk("win_delay", win_delay, (b[0][2:0] >= 3'h6) ? 4'h0 : 4'h7 - {1'b0, b[0][2:0]});
    chk("dbg_en", dbg_en, !b[1][5]);
    chk("store_en", store_en, !b[1][4]);
    chk("boot_en", boot_en, !b[1][3]);
    chk("boot_end", boot_end, exp_end(b[1]));
    chk("app_wb", app_wb, !b[2][7]);
    chk("store_wb", store_wb, !b[2][3] && !b[1][4]);
    chk("ee_wb", ee_wb, !b[2][2]);
    chk("cfg_wb", cfg_wb, !b[2][1]);
    chk("boot_wb", boot_wb, !b[2][0] && !b[1][3]);
    chk("cprot", cprot, !b[3][0]);
  endtask

  // Random image loaded while reset is held
  task automatic do_reset();
    wr_en = 1'b0;
    bulk_erase = 1'b0;
    nrst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      roll(nv[i]);
      b[i] = nv[i] & IMPL[i];
    end
    repeat (16) @(negedge ref_clk);
    chk("rst_full_open", full_open, 1'b1);
    chk("rst_clk_src", clk_src, 3'h0);
    chk("rst_refused", wr_refused, 1'b0);
    nrst = 1'b1;
  endtask

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog: far beyond the few thousand cycles the sequence needs
  initial begin
    #6000000;
    err_count++;
    report_and_stop();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] r, d;
    // Random images and writes, unmapped and erase among them, resets mid-run
    repeat (20) begin
      do_reset();
      repeat (12) begin
        roll(r);
        roll(d);
        wdt_mode = r[7:6];
        sleep = r[5];
        sw_en = r[4];
        wr(int'(r[2:0]) % 5, d, r[3:0] == 4'h9);
        check_all();
      end
    end
    // Every selector and window code under every watchdog mode
    wr(0, 8'h00, 1'b1);
    for (int k = 0; k < 32; k++) begin
      wdt_mode = 2'(k / 8);
      sleep = k[0];
      sw_en = k[1];
      wr(0, {2'b00, 3'(k), ~3'(k)}, 1'b0);
      check_all();
    end
    // Each boot size armed, then a frozen size and sticky enables tried
    for (int k = 0; k < 8; k++) begin
      wr(1, 8'h00, 1'b1);
      wr(1, {5'b00000, 3'(k)}, 1'b0);
      wr(1, {5'b00111, ~3'(k)}, 1'b0);
      wr(2, {k[0], 3'b000, k[1], k[2], 1'b1, k[0]}, 1'b0);
      check_all();
    end
    // Arm every write-protect bit, try to undo it, then erase in a colliding write
    wr(2, 8'h00, 1'b0);
    wr(0, 8'h15, 1'b0);
    wr(2, 8'hff, 1'b0);
    check_all();
    wr(2, 8'h00, 1'b1);
    check_all();
    report_and_stop();
  end
endmodule
